// ---- src/gpg_page.v ----
// general purpose register page: page select, gpio modes, hold pin and led tri-state
//
// Contract
// - writing 0x0010 to register 31 maps that port's addresses other than 31 onto the general page
// - writing 0x0000 to register 31 returns accesses to the main page
// - page bits survive per-port soft resets; only the global reset clears them
// - one page instance is shared by all four ports
// - page map places gpio control at 13 and second control at 14
// - reserved page addresses read zero and ignore writes
// - pins 0-7 have two-bit mode fields; code 11 gives register control
// - bits 15:14 of second control set one mode for pins 12-14
// - pins 8-11 modes sit in bits 7:0 of second control
// - bit 13 is an active-low output enable for the hold pin
// - hold pin drives bit 12 while configured as output
// - bit 11 reads the sampled hold pin level
// - bit 9 set releases led high levels to high impedance
// - under register control, oe, output and input registers own the pin
`timescale 1ns/1ps
`include "gpg_defs.vh"
module gpg_page #(
   parameter NPORTS = 4,
   parameter NGPIO = 15,
   parameter NLED = 4
) (
   // clock and global reset
   input wire clk,
   input wire rst,
   // per-port soft reset, does not touch page bits
   input wire [NPORTS-1:0] port_soft_rst,
   // management access from each port
   input wire [NPORTS-1:0] mgmt_wr,
   input wire [NPORTS-1:0] mgmt_rd,
   input wire [NPORTS*5-1:0] mgmt_addr,
   input wire [NPORTS*16-1:0] mgmt_wdata,
   output reg [15:0] mgmt_rdata,
   output reg mgmt_rvalid,
   output reg mgmt_main_sel,
   output reg [NPORTS-1:0] page_is_gp,
   // gpio pins
   input wire [NGPIO-1:0] gpio_in,
   output reg [NGPIO-1:0] gpio_out,
   output reg [NGPIO-1:0] gpio_oe,
   output reg [NGPIO-1:0] gpio_reg_ctrl,
   // low-power hold pin
   input wire low_power_hold_pin_in,
   output reg low_power_hold_pin_out,
   output reg low_power_hold_pin_oe,
   // led drivers
   input wire [NLED-1:0] led_level,
   output reg [NLED-1:0] led_out,
   output reg [NLED-1:0] led_oe
);
   wire [NPORTS*16-1:0] page_flat;
   reg [15:0] low_mode;
   reg [15:0] high_mode;
   reg [15:0] gp_out;
   reg [15:0] gp_oe;
   wire [NGPIO:0] pin_level;
   reg [NGPIO-1:0] next_reg_ctrl;
   reg [15:0] next_rdata;
   reg next_rvalid;
   reg next_main;
   reg [15:0] in_word;
   integer p;
   integer k;
   integer rp;
   integer pk;

   function [1:0] mode_of;
      input [15:0] lo;
      input [15:0] hi;
      input integer pin;
      begin
         if (pin < 8) begin
            mode_of = lo[2*pin +: 2];
         end else if (pin < 12) begin
            mode_of = hi[2*(pin-8) +: 2];
         end else begin
            mode_of = hi[15:14];
         end
      end
   endfunction

   // pins and hold input in one synchroniser
   gpg_sync #(.WIDTH(NGPIO+1)) u_sync (
      .clk(clk),
      .rst(rst),
      .pin({low_power_hold_pin_in, gpio_in}),
      .level(pin_level)
   );

   // page select is per port; only the page contents are shared
   // each port owns its select register, so no register has two drivers
   genvar g;
   generate
      for (g = 0; g < NPORTS; g = g + 1) begin : g_page
         reg [15:0] sel;
         always @(posedge clk) begin
            if (rst || port_soft_rst[g]) begin
               sel <= `GPG_PAGE_MAIN;
            end else if (mgmt_wr[g] && mgmt_addr[g*5 +: 5] == `GPG_PAGE_REG) begin
               sel <= mgmt_wdata[g*16 +: 16];
            end
         end
         assign page_flat[g*16 +: 16] = sel;
      end
   endgenerate

   // shared page; writes from lower ports win when two collide
   // soft resets are not in this reset term, which keeps the bits super-sticky
   always @(posedge clk) begin
      if (rst) begin
         low_mode <= `GPG_LOW_MODE_RST;
         high_mode <= `GPG_HIGH_MODE_RST;
         gp_out <= 16'h0000;
         gp_oe <= 16'h0000;
      end else begin
         for (p = NPORTS - 1; p >= 0; p = p - 1) begin
            if (mgmt_wr[p] && page_flat[p*16 +: 16] == `GPG_PAGE_GP) begin
               case (mgmt_addr[p*5 +: 5])
                  `GPG_ADDR_LOW_MODE: begin
                     low_mode <= mgmt_wdata[p*16 +: 16];
                  end
                  `GPG_ADDR_HIGH_MODE: begin
                     // bit 11 is live pin data, bit 8 read-only, both kept out
                     high_mode <= (mgmt_wdata[p*16 +: 16] & `GPG_HIGH_RW_MASK);
                  end
                  `GPG_ADDR_GPIO_OUT: begin
                     gp_out <= mgmt_wdata[p*16 +: 16] & `GPG_GPIO_MASK;
                  end
                  `GPG_ADDR_GPIO_OE: begin
                     gp_oe <= mgmt_wdata[p*16 +: 16] & `GPG_GPIO_MASK;
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   always @* begin
      in_word = 16'h0000;
      in_word[NGPIO-1:0] = pin_level[NGPIO-1:0];
      next_rdata = 16'h0000;
      next_rvalid = 1'b0;
      next_main = 1'b0;
      // one reader at a time: the lowest requesting port is answered
      for (rp = NPORTS - 1; rp >= 0; rp = rp - 1) begin
         if (mgmt_rd[rp]) begin
            next_rvalid = 1'b1;
            next_rdata = 16'h0000;
            next_main = 1'b0;
            if (mgmt_addr[rp*5 +: 5] == `GPG_PAGE_REG) begin
               next_rdata = page_flat[rp*16 +: 16];
            end else if (page_flat[rp*16 +: 16] != `GPG_PAGE_GP) begin
               next_main = 1'b1;
            end else begin
               case (mgmt_addr[rp*5 +: 5])
                  `GPG_ADDR_LOW_MODE: next_rdata = low_mode;
                  `GPG_ADDR_HIGH_MODE: begin
                     next_rdata = high_mode;
                     next_rdata[`GPG_BIT_HOLD_IN] = pin_level[NGPIO];
                  end
                  `GPG_ADDR_GPIO_IN: next_rdata = in_word;
                  `GPG_ADDR_GPIO_OUT: next_rdata = gp_out;
                  `GPG_ADDR_GPIO_OE: next_rdata = gp_oe;
                  default: next_rdata = 16'h0000;
               endcase
            end
         end
      end
      for (k = 0; k < NGPIO; k = k + 1) begin
         next_reg_ctrl[k] = (mode_of(low_mode, high_mode, k) == `GPG_MODE_REG_CTRL);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         mgmt_rdata <= 16'h0000;
         mgmt_rvalid <= 1'b0;
         mgmt_main_sel <= 1'b0;
         page_is_gp <= {NPORTS{1'b0}};
         gpio_out <= {NGPIO{1'b0}};
         gpio_oe <= {NGPIO{1'b0}};
         gpio_reg_ctrl <= {NGPIO{1'b0}};
         low_power_hold_pin_out <= 1'b0;
         low_power_hold_pin_oe <= 1'b0;
         led_out <= {NLED{1'b0}};
         led_oe <= {NLED{1'b0}};
      end else begin
         mgmt_rdata <= next_rdata;
         mgmt_rvalid <= next_rvalid;
         mgmt_main_sel <= next_main;
         for (pk = 0; pk < NPORTS; pk = pk + 1) begin
            page_is_gp[pk] <= (page_flat[pk*16 +: 16] == `GPG_PAGE_GP);
         end
         gpio_reg_ctrl <= next_reg_ctrl;
         // pins outside register control stay released; other functions are not here
         gpio_out <= gp_out[NGPIO-1:0] & next_reg_ctrl;
         gpio_oe <= gp_oe[NGPIO-1:0] & next_reg_ctrl;
         low_power_hold_pin_oe <= ~high_mode[`GPG_BIT_HOLD_OE_N];
         low_power_hold_pin_out <= high_mode[`GPG_BIT_HOLD_OUT];
         led_out <= led_level;
         if (high_mode[`GPG_BIT_LED_TRI]) begin
            led_oe <= ~led_level;
         end else begin
            led_oe <= {NLED{1'b1}};
         end
      end
   end
endmodule

// ---- src/gpg_defs.vh ----
// register offsets, field positions and reset values of the general purpose page
`ifndef GPG_DEFS_VH
`define GPG_DEFS_VH
`define GPG_PAGE_REG 5'h1f
`define GPG_PAGE_MAIN 16'h0000
`define GPG_PAGE_GP 16'h0010
`define GPG_ADDR_LOW_MODE 5'h0d
`define GPG_ADDR_HIGH_MODE 5'h0e
`define GPG_ADDR_GPIO_IN 5'h0f
`define GPG_ADDR_GPIO_OUT 5'h10
`define GPG_ADDR_GPIO_OE 5'h11
`define GPG_MODE_REG_CTRL 2'h3
`define GPG_LOW_MODE_RST 16'h0000
`define GPG_HIGH_MODE_RST 16'h2400
`define GPG_HIGH_RW_MASK 16'hf6ff
`define GPG_BIT_HOLD_OE_N 13
`define GPG_BIT_HOLD_OUT 12
`define GPG_BIT_HOLD_IN 11
`define GPG_BIT_LED_TRI 9
`define GPG_GPIO_MASK 16'h7fff
`endif

// ---- src/gpg_sync.v ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpg_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // pins and filtered levels
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] level
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   integer i;
   always @(posedge clk) begin
      if (rst) begin
         s1 <= {WIDTH{1'b0}};
         s2 <= {WIDTH{1'b0}};
         s3 <= {WIDTH{1'b0}};
         level <= {WIDTH{1'b0}};
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         // a bit changes only once stages two and three agree
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2[i] == s3[i]) begin
               level[i] <= s2[i];
            end
         end
      end
   end
endmodule

// ---- test/gpg_page_asserts.sv ----
// concurrent checks on the general purpose page ports
`timescale 1ns/1ps
module gpg_page_asserts #(
   parameter NPORTS = 4,
   parameter NGPIO = 15
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // management access
   input wire [NPORTS-1:0] port_soft_rst,
   input wire [NPORTS-1:0] mgmt_wr,
   input wire [NPORTS-1:0] mgmt_rd,
   input wire [NPORTS*5-1:0] mgmt_addr,
   input wire [NPORTS*16-1:0] mgmt_wdata,
   input wire [15:0] mgmt_rdata,
   input wire mgmt_rvalid,
   input wire mgmt_main_sel,
   input wire [NPORTS-1:0] page_is_gp,
   // pins
   input wire [NGPIO-1:0] gpio_reg_ctrl,
   input wire low_power_hold_pin_oe
);
   reg q1 = 1'b0;
   reg q2 = 1'b0;
   // page_is_gp lags its register, so only trust it after two quiet edges
   wire quiet = q1 & q2;
   wire rd0 = mgmt_rd == 1 && mgmt_addr[4:0] != 5'h1f;
   wire sel0 = mgmt_wr[0] && mgmt_addr[4:0] == 5'h1f && !port_soft_rst[0];
   always @(posedge clk) begin
      q1 <= (mgmt_wr | port_soft_rst) == 0;
      q2 <= q1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_RVALID: assert property (mgmt_rd != 0 |=> mgmt_rvalid)
      else $error("no read answer");
   AST_PAGE_SEL: assert property (sel0 && mgmt_wdata[15:0] == 16'h0010 |-> ##[1:2] page_is_gp[0])
      else $error("page not selected");
   AST_PAGE_MAIN: assert property (sel0 && mgmt_wdata[15:0] == 0 |-> ##[1:2] !page_is_gp[0])
      else $error("main page not restored");
   AST_MAIN_ZERO: assert property (mgmt_rvalid && mgmt_main_sel |-> mgmt_rdata == 0)
      else $error("main read data");
   AST_MAIN_SEL: assert property (rd0 && quiet && !page_is_gp[0] |=> mgmt_main_sel)
      else $error("read not sent to main page");
   AST_RES_ZERO: assert property (rd0 && quiet && page_is_gp[0] && mgmt_addr[4:0] < 13
      |=> !mgmt_main_sel && mgmt_rdata == 0)
      else $error("reserved read");
   AST_PIN_HOLD: assert property ((mgmt_wr == 0) [*3]
      |=> $stable(gpio_reg_ctrl) && $stable(low_power_hold_pin_oe))
      else $error("pin control moved");
   AST_HOLD_RST: assert property ($fell(rst) |-> !low_power_hold_pin_oe && gpio_reg_ctrl == 0)
      else $error("reset pin state");
endmodule
bind gpg_page gpg_page_asserts #(.NPORTS(NPORTS), .NGPIO(NGPIO)) u_asserts (.*);

// ---- test/tb_gp_page_gpio_control.sv ----
// self-checking bench for the general purpose page
`timescale 1ns/1ps
module tb_gp_page_gpio_control;
   reg clk = 0;
   reg rst = 1;
   reg [3:0] port_soft_rst = 0, mgmt_wr = 0, mgmt_rd = 0, led_level = 0;
   reg [19:0] mgmt_addr = 0;
   reg [63:0] mgmt_wdata = 0;
   reg [14:0] gpio_in = 0;
   reg low_power_hold_pin_in = 0;
   wire [15:0] mgmt_rdata;
   wire mgmt_rvalid, mgmt_main_sel, low_power_hold_pin_out, low_power_hold_pin_oe;
   wire [3:0] page_is_gp, led_out, led_oe;
   wire [14:0] gpio_out, gpio_oe, gpio_reg_ctrl, c;
   integer errors = 0, num_checks = 0, i;
   reg [31:0] s = 32'hcf59;
   reg [15:0] d, lo, hi, o, e;
   reg m;
   gpg_page dut (
      .clk(clk),
      .rst(rst),
      .port_soft_rst(port_soft_rst),
      .mgmt_wr(mgmt_wr),
      .mgmt_rd(mgmt_rd),
      .mgmt_addr(mgmt_addr),
      .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata(mgmt_rdata),
      .mgmt_rvalid(mgmt_rvalid),
      .mgmt_main_sel(mgmt_main_sel),
      .page_is_gp(page_is_gp),
      .gpio_in(gpio_in),
      .gpio_out(gpio_out),
      .gpio_oe(gpio_oe),
      .gpio_reg_ctrl(gpio_reg_ctrl),
      .low_power_hold_pin_in(low_power_hold_pin_in),
      .low_power_hold_pin_out(low_power_hold_pin_out),
      .low_power_hold_pin_oe(low_power_hold_pin_oe),
      .led_level(led_level),
      .led_out(led_out),
      .led_oe(led_oe)
   );
   initial forever #20 clk = ~clk;
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function [14:0] rc(input [15:0] l, input [15:0] h);
      integer k;
      begin
         for (k = 0; k < 8; k = k + 1) rc[k] = &l[2*k+:2];
         for (k = 0; k < 4; k = k + 1) rc[8+k] = &h[2*k+:2];
         rc[14:12] = {3{&h[15:14]}};
      end
   endfunction
   assign c = rc(lo, hi);
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input integer p, input [4:0] a, input [15:0] v);
      begin
         mgmt_wr[p] = 1;
         mgmt_addr[p*5+:5] = a;
         mgmt_wdata[p*16+:16] = v;
         cyc(1);
         mgmt_wr = 0;
         // an idle edge keeps two strobes in a row apart
         cyc(1);
      end
   endtask
   // the answer comes exactly one edge after the strobe
   task rd(input integer p, input [4:0] a);
      begin
         mgmt_rd[p] = 1;
         mgmt_addr[p*5+:5] = a;
         cyc(1);
         chk(mgmt_rvalid, 1);
         d = mgmt_rdata;
         m = mgmt_main_sel;
         mgmt_rd = 0;
         cyc(1);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #400000;
      errors = errors + 1;
      summarize;
   end
   initial begin
      cyc(20);
      rst = 0;
      rd(0, 13);
      chk(m, 1);
      wr(0, 31, 16'h0010);
      cyc(2);
      chk(page_is_gp, 1);
      rd(0, 13);
      chk(d, 0);
      rd(0, 14);
      chk(d, 16'h2400);
      wr(0, 14, 16'hffff);
      wr(0, 15, 16'hffff);
      wr(0, 5, 16'hffff);
      rd(0, 14);
      chk(d, 16'hf6ff);
      rd(0, 15);
      chk(d, 0);
      rd(0, 5);
      chk(d, 0);
      for (i = 0; i < 12; i = i + 1) begin
         s = lfsr(s);
         lo = i == 0 ? 16'hffff : s[15:0];
         hi = i == 1 ? 16'hdfff : s[31:16];
         s = lfsr(s);
         o = s[15:0];
         e = s[31:16];
         wr(0, 13, lo);
         wr(0, 14, hi);
         wr(0, 16, o);
         wr(0, 17, e);
         gpio_in = s[14:0];
         low_power_hold_pin_in = s[20];
         led_level = s[23:20];
         cyc(6);
         chk(gpio_reg_ctrl, c);
         chk(gpio_oe, e[14:0] & c);
         chk(gpio_out, o[14:0] & c);
         chk(low_power_hold_pin_oe, !hi[13]);
         if (!hi[13]) chk(low_power_hold_pin_out, hi[12]);
         chk(led_oe, hi[9] ? led_level ^ 4'hf : 4'hf);
         if (!hi[9]) chk(led_out, led_level);
         rd(0, 14);
         chk(d, hi & 16'hf6ff | {s[20], 11'h0});
         rd(0, 15);
         chk(d, {1'b0, s[14:0]});
      end
      wr(2, 31, 16'h0010);
      cyc(2);
      rd(2, 13);
      chk(d, lo);
      port_soft_rst = 1;
      cyc(1);
      port_soft_rst = 0;
      cyc(2);
      chk(page_is_gp, 4);
      rd(2, 13);
      chk(d, lo);
      wr(0, 31, 0);
      wr(2, 31, 0);
      cyc(2);
      rd(2, 13);
      chk(m, 1);
      // only the global reset clears the shared page
      rst = 1;
      cyc(2);
      rst = 0;
      wr(0, 31, 16'h0010);
      rd(0, 13);
      chk(d, 0);
      rd(0, 14);
      chk(d & 16'hf7ff, 16'h2400);
      summarize;
   end
endmodule
